// ==== logic/timer_pkg.sv ====
// constants and register map for the compare and pwm timer
// Behaviour
// - counter match drives pin to configured level
// - three-bit source select picks count source
// - free-run 65536 or clear at period match
// - run bit starts, clearing it holds counter
// - stopped compare outputs keep their level
// - flags raised on every match and overflow
// - counter readable and writable at any time
// - match action: low, high or toggle
// - initial level holds until first match
// - each pin port or compare output
// - registers c and d buffer a and b
// - writing level control drives initial level
// - pwm on pins b, c, d only
// - period m+1, inactive n+1, active m-n
// - level bit sets pwm start and inactive level
// - any pwm pin reserves the period register
// - change point equal period gives no change
// - pwm buffers: c next period, d next b
// - stopped pwm holds pins and counter
// - pin a level bit ignored in pwm
// - cutoff low sets all four disable bits
// - cutoff takes pins within few clocks
package timer_pkg;
   localparam int AW = 12;
   localparam int DW = 16;
   // register offsets
   localparam logic [11:0] MODE_OFS   = 12'h120;
   localparam logic [11:0] CTRL_OFS   = 12'h121;
   localparam logic [11:0] IOAB_OFS   = 12'h124;
   localparam logic [11:0] IOCD_OFS   = 12'h125;
   localparam logic [11:0] STAT_OFS   = 12'h126;
   localparam logic [11:0] OEN_OFS    = 12'h127;
   localparam logic [11:0] CNT_OFS    = 12'h128;
   localparam logic [11:0] GRA_OFS    = 12'h12a;
   localparam logic [11:0] GRB_OFS    = 12'h12c;
   localparam logic [11:0] GRC_OFS    = 12'h12e;
   localparam logic [11:0] GRD_OFS    = 12'h130;
   // mode_register fields
   localparam int RUN_BIT  = 7;
   localparam int BFD_BIT  = 5;
   localparam int BFC_BIT  = 4;
   localparam int PWM_LSB  = 1;
   // counter_output_control fields
   localparam int CLR_BIT  = 7;
   localparam int SRC_LSB  = 4;
   // io_control fields: two per register, nibble each
   localparam int FSEL_BIT = 2;
   // output_enable_register fields
   localparam int CUT_BIT  = 7;
   // reset values
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] IO_RST   = 8'h00;
   localparam logic [7:0] OEN_RST  = 8'h0f;
   localparam logic [15:0] GR_RST  = 16'hffff;
   // count source codes
   localparam logic [2:0] SRC_F1  = 3'h0;
   localparam logic [2:0] SRC_F2  = 3'h1;
   localparam logic [2:0] SRC_F4  = 3'h2;
   localparam logic [2:0] SRC_F8  = 3'h3;
   localparam logic [2:0] SRC_F32 = 3'h4;
   localparam logic [2:0] SRC_EXT = 3'h5;
   localparam logic [2:0] SRC_OSC = 3'h6;
   // match actions
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_LOW  = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOG  = 2'h3;
   // cutoff reaction bound in clocks (sync plus register)
   localparam int CUT_CYC = 4;
endpackage

// ==== logic/output_compare_pwm_timer.sv ====
// 16-bit compare and pwm timer with register port
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module output_compare_pwm_timer (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [11:0] addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [15:0] rdata,
   input  wire logic        external_count_clock_pin,
   input  wire logic        internal_fast_oscillator,
   input  wire logic        cutoff_interrupt_pin_n,
   output logic             wave_pin_a,
   output logic             wave_pin_b,
   output logic             wave_pin_c,
   output logic             wave_pin_d,
   output logic             wave_pin_a_oe_n,
   output logic             wave_pin_b_oe_n,
   output logic             wave_pin_c_oe_n,
   output logic             wave_pin_d_oe_n
);
   logic [7:0]  mode_reg;
   logic [7:0]  ctrl_reg;
   logic [7:0]  ioab_reg;
   logic [7:0]  iocd_reg;
   logic [7:0]  oen_reg;
   logic [4:0]  flag_reg;
   logic [15:0] cnt_reg;
   logic [15:0] gr_reg [4];
   logic [3:0]  lvl_reg;
   logic [3:0]  oe_n_reg;
   logic [15:0] rdata_reg;
   logic [4:0]  pre_reg;
   logic [2:0]  ext_sync;
   logic [2:0]  osc_sync;
   logic [1:0]  cut_sync;
   logic        tick;
   logic        running;
   logic        step;
   logic [3:0]  hit;
   logic        clr;
   logic        ovf;
   logic [3:0]  pwm;
   logic        pwm_any;
   logic [1:0]  act [4];
   logic [3:0]  fsel;
   logic [3:0]  dis_next;
   logic        wr_mode;
   logic        wr_ctrl;
   logic        wr_cnt;

   assign wr_mode = wr_en && addr == timer_pkg::MODE_OFS;
   assign wr_ctrl = wr_en && addr == timer_pkg::CTRL_OFS;
   assign wr_cnt  = wr_en && addr == timer_pkg::CNT_OFS;
   assign running = mode_reg[timer_pkg::RUN_BIT];
   assign pwm     = {mode_reg[timer_pkg::PWM_LSB +: 3], 1'b0};
   assign pwm_any = |pwm;
   assign act[0]  = ioab_reg[1:0];
   assign act[1]  = ioab_reg[5:4];
   assign act[2]  = iocd_reg[1:0];
   assign act[3]  = iocd_reg[5:4];
   assign fsel    = {iocd_reg[4 + timer_pkg::FSEL_BIT], iocd_reg[timer_pkg::FSEL_BIT],
                     ioab_reg[4 + timer_pkg::FSEL_BIT], ioab_reg[timer_pkg::FSEL_BIT]};

   // prescaler for the divided sources
   always_ff @(posedge clk) begin
      if (rst) begin
         pre_reg <= 5'h00;
      end else begin
         pre_reg <= pre_reg + 5'h01;
      end
   end

   // pin sources pass two flops; edge taken after the second
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_sync <= 3'h0;
         osc_sync <= 3'h0;
         cut_sync <= 2'h3;
      end else begin
         ext_sync <= {ext_sync[1:0], external_count_clock_pin};
         osc_sync <= {osc_sync[1:0], internal_fast_oscillator};
         cut_sync <= {cut_sync[0], cutoff_interrupt_pin_n};
      end
   end

   // count source select; code 111 never ticks
   always_comb begin
      unique case (ctrl_reg[timer_pkg::SRC_LSB +: 3])
         timer_pkg::SRC_F1:  tick = 1'b1;
         timer_pkg::SRC_F2:  tick = pre_reg[0];
         timer_pkg::SRC_F4:  tick = &pre_reg[1:0];
         timer_pkg::SRC_F8:  tick = &pre_reg[2:0];
         timer_pkg::SRC_F32: tick = &pre_reg[4:0];
         timer_pkg::SRC_EXT: tick = ext_sync[1] & ~ext_sync[2];
         timer_pkg::SRC_OSC: tick = osc_sync[1] & ~osc_sync[2];
         default:            tick = 1'b0;
      endcase
   end

   // match and wrap events are only seen on a counting step
   always_comb begin
      step = running && tick;
      for (int i = 0; i < 4; i++) begin
         hit[i] = step && cnt_reg == gr_reg[i];
      end
      // period register clears the count in pwm or with clear select
      clr = hit[0] && (ctrl_reg[timer_pkg::CLR_BIT] || pwm_any);
      ovf = step && cnt_reg == 16'hffff && !clr;
   end

   // counter; software write wins over counting
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= 16'h0000;
      end else if (wr_cnt) begin
         cnt_reg <= wdata;
      end else if (clr) begin
         cnt_reg <= 16'h0000;
      end else if (step) begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   // control registers
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_reg <= timer_pkg::MODE_RST;
         ctrl_reg <= timer_pkg::CTRL_RST;
         ioab_reg <= timer_pkg::IO_RST;
         iocd_reg <= timer_pkg::IO_RST;
      end else if (wr_en) begin
         if (wr_mode) mode_reg <= wdata[7:0];
         if (wr_ctrl) ctrl_reg <= wdata[7:0];
         if (addr == timer_pkg::IOAB_OFS) ioab_reg <= wdata[7:0];
         if (addr == timer_pkg::IOCD_OFS) iocd_reg <= wdata[7:0];
      end
   end

   // general registers with buffer transfers; software write wins
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) begin
            gr_reg[i] <= timer_pkg::GR_RST;
         end
      end else begin
         // compare mode loads at own match, pwm at period end
         if (mode_reg[timer_pkg::BFC_BIT] && hit[0]) begin
            gr_reg[0] <= gr_reg[2];
         end
         if (mode_reg[timer_pkg::BFD_BIT] && (pwm[1] ? hit[0] : hit[1])) begin
            gr_reg[1] <= gr_reg[3];
         end
         if (wr_en) begin
            if (addr == timer_pkg::GRA_OFS) gr_reg[0] <= wdata;
            if (addr == timer_pkg::GRB_OFS) gr_reg[1] <= wdata;
            if (addr == timer_pkg::GRC_OFS) gr_reg[2] <= wdata;
            if (addr == timer_pkg::GRD_OFS) gr_reg[3] <= wdata;
         end
      end
   end

   // sticky flags; a write of 0 clears, a new event wins
   always_ff @(posedge clk) begin
      if (rst) begin
         flag_reg <= 5'h00;
      end else if (wr_en && addr == timer_pkg::STAT_OFS) begin
         flag_reg <= (flag_reg & wdata[4:0]) | {ovf, hit};
      end else begin
         flag_reg <= flag_reg | {ovf, hit};
      end
   end

   // cutoff pin sets all disables; later software may clear them
   always_comb begin
      dis_next = oen_reg[3:0];
      if (wr_en && addr == timer_pkg::OEN_OFS) dis_next = wdata[3:0];
      if (oen_reg[timer_pkg::CUT_BIT] && !cut_sync[1]) dis_next = 4'hf;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         oen_reg <= timer_pkg::OEN_RST;
      end else begin
         oen_reg[3:0] <= dis_next;
         if (wr_en && addr == timer_pkg::OEN_OFS) begin
            oen_reg[7:4] <= wdata[7:4];
         end
      end
   end

   // pin levels: initial level on setup write, then match actions
   always_ff @(posedge clk) begin
      if (rst) begin
         lvl_reg <= 4'h0;
      end else if (wr_ctrl) begin
         lvl_reg <= wdata[3:0];
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (pwm[i]) begin
               // period end returns to inactive; change point to active
               if (hit[0]) begin
                  lvl_reg[i] <= ctrl_reg[i];
               end else if (hit[i] && gr_reg[i] != gr_reg[0]) begin
                  lvl_reg[i] <= ~ctrl_reg[i];
               end
            end else if (hit[i]) begin
               unique case (act[i])
                  timer_pkg::ACT_LOW:  lvl_reg[i] <= 1'b0;
                  timer_pkg::ACT_HIGH: lvl_reg[i] <= 1'b1;
                  timer_pkg::ACT_TOG:  lvl_reg[i] <= ~lvl_reg[i];
                  timer_pkg::ACT_NONE: lvl_reg[i] <= lvl_reg[i];
               endcase
            end
         end
      end
   end

   // pin drive; buffer registers outside pwm and pin a in pwm never drive
   always_ff @(posedge clk) begin
      if (rst) begin
         oe_n_reg <= 4'hf;
      end else begin
         for (int i = 0; i < 4; i++) begin
            oe_n_reg[i] <= dis_next[i] || !(pwm[i] || (!fsel[i] && act[i] != timer_pkg::ACT_NONE));
         end
         if (pwm_any) oe_n_reg[0] <= 1'b1;
         if (mode_reg[timer_pkg::BFC_BIT] && !pwm[2]) oe_n_reg[2] <= 1'b1;
         if (mode_reg[timer_pkg::BFD_BIT] && !pwm[3]) oe_n_reg[3] <= 1'b1;
      end
   end

   assign wave_pin_a      = lvl_reg[0];
   assign wave_pin_b      = lvl_reg[1];
   assign wave_pin_c      = lvl_reg[2];
   assign wave_pin_d      = lvl_reg[3];
   assign wave_pin_a_oe_n = oe_n_reg[0];
   assign wave_pin_b_oe_n = oe_n_reg[1];
   assign wave_pin_c_oe_n = oe_n_reg[2];
   assign wave_pin_d_oe_n = oe_n_reg[3];

   // read data in the cycle after the strobe, zero otherwise
   always_ff @(posedge clk) begin
      if (rst || !rd_en) begin
         rdata_reg <= 16'h0000;
      end else begin
         unique case (addr)
            timer_pkg::MODE_OFS: rdata_reg <= {8'h00, mode_reg};
            timer_pkg::CTRL_OFS: rdata_reg <= {8'h00, ctrl_reg};
            timer_pkg::IOAB_OFS: rdata_reg <= {8'h00, ioab_reg};
            timer_pkg::IOCD_OFS: rdata_reg <= {8'h00, iocd_reg};
            timer_pkg::STAT_OFS: rdata_reg <= {11'h000, flag_reg};
            timer_pkg::OEN_OFS:  rdata_reg <= {8'h00, oen_reg};
            timer_pkg::CNT_OFS:  rdata_reg <= cnt_reg;
            timer_pkg::GRA_OFS:  rdata_reg <= gr_reg[0];
            timer_pkg::GRB_OFS:  rdata_reg <= gr_reg[1];
            timer_pkg::GRC_OFS:  rdata_reg <= gr_reg[2];
            timer_pkg::GRD_OFS:  rdata_reg <= gr_reg[3];
            default:             rdata_reg <= 16'h0000;
         endcase
      end
   end
   assign rdata = rdata_reg;

   // checks
   sequence s_cut_low;
      oen_reg[timer_pkg::CUT_BIT] && !cutoff_interrupt_pin_n ##1 !cutoff_interrupt_pin_n;
   endsequence
   sequence s_all_off;
      ##[1:3] (oen_reg[3:0] == 4'hf && oe_n_reg == 4'hf);
   endsequence

   a_cut_disables: assert property (@(posedge clk) disable iff (rst)
      s_cut_low ##1 !cutoff_interrupt_pin_n |-> s_all_off)
      else $error("cutoff did not disable pins");
   a_stop_holds: assert property (@(posedge clk) disable iff (rst)
      !running && !wr_cnt |=> $stable(cnt_reg))
      else $error("stopped counter moved");
   a_stop_pins: assert property (@(posedge clk) disable iff (rst)
      !running && !wr_ctrl |=> $stable(lvl_reg))
      else $error("pin level changed while stopped");
   a_clear_period: assert property (@(posedge clk) disable iff (rst)
      step && cnt_reg == gr_reg[0] && (ctrl_reg[7] || pwm_any) && !wr_cnt
      |=> cnt_reg == 16'h0000)
      else $error("period match did not clear");
   a_wrap_flag: assert property (@(posedge clk) disable iff (rst)
      step && cnt_reg == 16'hffff && !clr && !wr_cnt |=> cnt_reg == 16'h0000 && flag_reg[4])
      else $error("wrap or overflow flag wrong");
   a_match_flag: assert property (@(posedge clk) disable iff (rst)
      step && cnt_reg == gr_reg[1] |=> flag_reg[1])
      else $error("match flag not set");
   a_init_level: assert property (@(posedge clk) disable iff (rst)
      wr_ctrl |=> lvl_reg == $past(wdata[3:0]))
      else $error("initial level not driven");
   a_pwm_period: assert property (@(posedge clk) disable iff (rst)
      pwm[1] && hit[0] && !wr_ctrl |=> wave_pin_b == ctrl_reg[1])
      else $error("pwm pin not inactive at period end");
   // an equal change point must never take the pin active
   a_pwm_equal: assert property (@(posedge clk) disable iff (rst)
      pwm[1] && hit[1] && gr_reg[1] == gr_reg[0] && !wr_ctrl
      |=> wave_pin_b == ctrl_reg[1])
      else $error("pwm pin changed on equal compare");
   a_no_tick_bad: assert property (@(posedge clk) disable iff (rst)
      ctrl_reg[6:4] == 3'h7 && !wr_cnt |=> $stable(cnt_reg))
      else $error("forbidden source counted");
   a_pwm_pin_a: assert property (@(posedge clk) disable iff (rst)
      pwm_any |=> wave_pin_a_oe_n)
      else $error("pin a driven in pwm");
   a_buf_load: assert property (@(posedge clk) disable iff (rst)
      mode_reg[4] && hit[0] && !wr_en |=> gr_reg[0] == $past(gr_reg[2]))
      else $error("buffer not loaded at match");

   // match actions on pin a; pin a keeps them even in pwm, only undriven
   a_act_low: assert property (@(posedge clk) disable iff (rst)
      hit[0] && act[0] == timer_pkg::ACT_LOW && !wr_ctrl |=> !wave_pin_a)
      else $error("low action not applied");
   a_act_high: assert property (@(posedge clk) disable iff (rst)
      hit[0] && act[0] == timer_pkg::ACT_HIGH && !wr_ctrl |=> wave_pin_a)
      else $error("high action not applied");
   a_act_toggle: assert property (@(posedge clk) disable iff (rst)
      hit[0] && act[0] == timer_pkg::ACT_TOG && !wr_ctrl |=> wave_pin_a != $past(wave_pin_a))
      else $error("toggle action not applied");

   // pwm change point takes the pin to its active level
   a_pwm_active: assert property (@(posedge clk) disable iff (rst)
      pwm[1] && hit[1] && !hit[0] && !wr_ctrl |=> wave_pin_b == !ctrl_reg[1])
      else $error("pwm pin not active after change point");
   a_pwm_d_period: assert property (@(posedge clk) disable iff (rst)
      pwm[3] && hit[0] && !wr_ctrl |=> wave_pin_d == ctrl_reg[3])
      else $error("pwm pin d not inactive at period end");
   a_pwm_b_drive: assert property (@(posedge clk) disable iff (rst)
      pwm[1] && !dis_next[1] |=> !wave_pin_b_oe_n)
      else $error("pwm pin b not driven");

   // counter write and plain counting step
   a_cnt_write: assert property (@(posedge clk) disable iff (rst)
      wr_cnt |=> cnt_reg == $past(wdata))
      else $error("counter write lost");
   a_cnt_step: assert property (@(posedge clk) disable iff (rst)
      step && !clr && !wr_cnt |=> cnt_reg == $past(cnt_reg) + 16'h0001)
      else $error("counter did not step");
   // external source only counts on a synchronised rising edge
   a_src_ext: assert property (@(posedge clk) disable iff (rst)
      ctrl_reg[6:4] == timer_pkg::SRC_EXT && !(ext_sync[1] && !ext_sync[2]) && !wr_cnt
      |=> $stable(cnt_reg))
      else $error("external source counted without edge");

   // flags stay until software clears them
   a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
      flag_reg[4] && !(wr_en && addr == timer_pkg::STAT_OFS) |=> flag_reg[4])
      else $error("overflow flag lost");

   // disabled pins, and buffering pins outside pwm, never drive
   a_pin_disabled: assert property (@(posedge clk) disable iff (rst)
      dis_next[1] |=> wave_pin_b_oe_n)
      else $error("disabled pin driven");
   a_buf_pin_c: assert property (@(posedge clk) disable iff (rst)
      mode_reg[timer_pkg::BFC_BIT] && !pwm[2] |=> wave_pin_c_oe_n)
      else $error("buffer register pin driven");
   // cutoff keeps the disables set while the synced pin stays low
   a_cut_hold: assert property (@(posedge clk) disable iff (rst)
      oen_reg[timer_pkg::CUT_BIT] && !cut_sync[1] |=> oen_reg[3:0] == 4'hf)
      else $error("cutoff did not hold disables");

   // pwm buffer of b loads at the period end, not at its own match
   sequence s_b_buffered;
      mode_reg[timer_pkg::BFD_BIT] && pwm[1] && hit[0] && !wr_en;
   endsequence
   a_pwm_buf: assert property (@(posedge clk) disable iff (rst)
      s_b_buffered |=> gr_reg[1] == $past(gr_reg[3]))
      else $error("pwm change point not reloaded");

   // read data stands one cycle only, zero otherwise
   a_rd_idle: assert property (@(posedge clk) disable iff (rst)
      !rd_en |=> rdata == 16'h0000)
      else $error("read data outside its cycle");
endmodule

// ==== tb/pin_load_model.sv ====
// load model on the far side of the wave pins
`timescale 1ns/1ps
module pin_load_model (
   input  wire logic [3:0] level,
   input  wire logic [3:0] oe_n,
   output logic      [3:0] line
);
   // a released pin falls to the pull-down, never keeps the last level
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         line[i] = oe_n[i] ? 1'b0 : level[i];
      end
   end
endmodule

// ==== tb/tb_output_compare_pwm_timer.sv ====
// self-checking bench for the compare and pwm timer
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_output_compare_pwm_timer;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [11:0] addr = 12'h000;
   logic [15:0] wdata = 16'h0000;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic [15:0] rdata;
   logic        cutoff_n = 1'b1;
   logic [2:0]  tick = 3'h0;
   logic [3:0]  lvl;
   logic [3:0]  oen;
   logic [3:0]  line;
   int          error_cnt = 0;
   int          checked = 0;
   output_compare_pwm_timer dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .external_count_clock_pin(tick[2]),
      .internal_fast_oscillator(tick[1]), .cutoff_interrupt_pin_n(cutoff_n),
      .wave_pin_a(lvl[0]), .wave_pin_b(lvl[1]), .wave_pin_c(lvl[2]), .wave_pin_d(lvl[3]),
      .wave_pin_a_oe_n(oen[0]), .wave_pin_b_oe_n(oen[1]), .wave_pin_c_oe_n(oen[2]),
      .wave_pin_d_oe_n(oen[3]));
   pin_load_model load (.level(lvl), .oe_n(oen), .line(line));
   always #20 clk = ~clk;
   // ext pin period 8 clocks, oscillator period 4 clocks
   always @(posedge clk) tick <= tick + 3'h1;
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk); addr <= a; wdata <= d; wr_en <= 1'b1;
      @(posedge clk); wr_en <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [15:0] d);
      @(posedge clk); addr <= a; rd_en <= 1'b1;
      @(posedge clk); rd_en <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // 50 samples span exactly five pwm periods of 10 in t_pwm, ten periods of 5 in t_buffer
   task automatic measure(input int i, output int hi, output int ed);
      logic p;
      hi = 0; ed = 0; p = line[i];
      repeat (50) begin
         @(posedge clk); #1;
         hi += line[i]; ed += (line[i] != p); p = line[i];
      end
   endtask
   task automatic t_reset();
      logic [15:0] v;
      `CHK(oen, 4'hf)
      rd(timer_pkg::CTRL_OFS, v); `CHK(v, 16'h0000)
      rd(timer_pkg::OEN_OFS, v); `CHK(v, 16'h000f)
      rd(timer_pkg::GRA_OFS, v); `CHK(v, 16'hffff)
      wr(12'h200, 16'h5a5a); rd(12'h200, v); `CHK(v, 16'h0000)
   endtask
   task automatic t_count();
      logic [15:0] c1, c2;
      wr(timer_pkg::CNT_OFS, 16'h1234); rd(timer_pkg::CNT_OFS, c1); `CHK(c1, 16'h1234)
      wr(timer_pkg::MODE_OFS, 16'h0080); cyc(10); wr(timer_pkg::MODE_OFS, 16'h0000);
      rd(timer_pkg::CNT_OFS, c1); cyc(10); rd(timer_pkg::CNT_OFS, c2);
      `CHK(c2, c1)
      `CHK(c1 >= 16'h123d && c1 <= 16'h1242, 1'b1)
   endtask
   task automatic t_sources();
      int div[7] = '{1, 2, 4, 8, 32, 8, 4};
      logic [15:0] v;
      int e;
      for (int k = 0; k < 7; k++) begin
         wr(timer_pkg::CTRL_OFS, 16'(k << 4)); wr(timer_pkg::CNT_OFS, 16'h0000);
         wr(timer_pkg::MODE_OFS, 16'h0080); cyc(127); wr(timer_pkg::MODE_OFS, 16'h0000);
         rd(timer_pkg::CNT_OFS, v); e = 128 / div[k];
         `CHK(int'(v) >= e - 2 && int'(v) <= e + 2, 1'b1)
      end
      // forbidden source code must never count
      wr(timer_pkg::CTRL_OFS, 16'h0070); wr(timer_pkg::CNT_OFS, 16'h0000);
      wr(timer_pkg::MODE_OFS, 16'h0080); cyc(20); wr(timer_pkg::MODE_OFS, 16'h0000);
      rd(timer_pkg::CNT_OFS, v); `CHK(v, 16'h0000)
   endtask
   task automatic t_compare();
      logic [1:0] act[3] = '{timer_pkg::ACT_LOW, timer_pkg::ACT_HIGH, timer_pkg::ACT_TOG};
      logic ini[3] = '{1'b1, 1'b0, 1'b0};
      logic [15:0] v;
      int n;
      for (int k = 0; k < 3; k++) begin
         wr(timer_pkg::MODE_OFS, 16'h0000); wr(timer_pkg::CNT_OFS, 16'h0000);
         wr(timer_pkg::STAT_OFS, 16'h0000); wr(timer_pkg::OEN_OFS, 16'h0000);
         wr(timer_pkg::GRA_OFS, 16'd20); wr(timer_pkg::IOAB_OFS, {14'h0, act[k]});
         wr(timer_pkg::CTRL_OFS, {15'h0040, ini[k]}); cyc(2);
         `CHK(line[0], ini[k])
         `CHK(oen[0], 1'b0)
         wr(timer_pkg::MODE_OFS, 16'h0080); n = 0;
         while (line[0] === ini[k] && n < 60) begin cyc(1); n++; end
         `CHK(n >= 18 && n <= 24, 1'b1)
         `CHK(line[0], ~ini[k])
         rd(timer_pkg::STAT_OFS, v); `CHK(v[0], 1'b1)
         wr(timer_pkg::MODE_OFS, 16'h0000); cyc(30);
         `CHK(line[0], ~ini[k])
         // clear select restarted the count at the match, free run would show 25
         rd(timer_pkg::CNT_OFS, v); `CHK(v <= 16'h0008, 1'b1)
      end
   endtask
   task automatic t_overflow();
      logic [15:0] v;
      wr(timer_pkg::CTRL_OFS, 16'h0000); wr(timer_pkg::STAT_OFS, 16'h0000);
      wr(timer_pkg::CNT_OFS, 16'hfffd); wr(timer_pkg::MODE_OFS, 16'h0080); cyc(8);
      wr(timer_pkg::MODE_OFS, 16'h0000);
      rd(timer_pkg::STAT_OFS, v); `CHK(v[4], 1'b1)
      rd(timer_pkg::CNT_OFS, v); `CHK(v >= 16'h0005 && v <= 16'h000c, 1'b1)
   endtask
   task automatic t_pwm();
      int hi, ed;
      logic p;
      logic [15:0] c1, c2;
      wr(timer_pkg::IOAB_OFS, 16'h0000); wr(timer_pkg::GRA_OFS, 16'd9);
      wr(timer_pkg::GRB_OFS, 16'd3); wr(timer_pkg::CTRL_OFS, 16'h0000);
      wr(timer_pkg::CNT_OFS, 16'h0000); wr(timer_pkg::MODE_OFS, 16'h0082); cyc(30);
      `CHK(oen[1], 1'b0)
      `CHK(oen[0], 1'b1)
      measure(1, hi, ed);
      `CHK(hi, 30)
      `CHK(ed, 10)
      wr(timer_pkg::GRB_OFS, 16'd9); cyc(30); measure(1, hi, ed);
      `CHK(ed, 0)
      wr(timer_pkg::MODE_OFS, 16'h0000); cyc(1); p = line[1]; rd(timer_pkg::CNT_OFS, c1);
      cyc(20); rd(timer_pkg::CNT_OFS, c2);
      `CHK(line[1], p)
      `CHK(c2, c1)
      // level bit a set too, it must stay without effect
      wr(timer_pkg::GRB_OFS, 16'd3); wr(timer_pkg::CTRL_OFS, 16'h0003);
      wr(timer_pkg::MODE_OFS, 16'h0082); cyc(30); measure(1, hi, ed);
      `CHK(hi, 20)
      `CHK(oen[0], 1'b1)
   endtask
   task automatic t_buffer();
      logic [15:0] v;
      int hi, ed;
      wr(timer_pkg::MODE_OFS, 16'h0000); wr(timer_pkg::IOAB_OFS, 16'h0003);
      wr(timer_pkg::IOCD_OFS, 16'h0001);
      wr(timer_pkg::GRA_OFS, 16'd9); wr(timer_pkg::GRC_OFS, 16'd19);
      wr(timer_pkg::CTRL_OFS, 16'h0080); wr(timer_pkg::CNT_OFS, 16'h0000);
      wr(timer_pkg::MODE_OFS, 16'h0090); cyc(5);
      rd(timer_pkg::GRA_OFS, v); `CHK(v, 16'd9)
      cyc(10); rd(timer_pkg::GRA_OFS, v); `CHK(v, 16'd19)
      `CHK(oen[2], 1'b1)
      // pwm: c holds the next period, d the next change point of b
      wr(timer_pkg::MODE_OFS, 16'h0000); wr(timer_pkg::CTRL_OFS, 16'h0000);
      wr(timer_pkg::GRA_OFS, 16'd9); wr(timer_pkg::GRB_OFS, 16'd3);
      wr(timer_pkg::GRC_OFS, 16'd4); wr(timer_pkg::GRD_OFS, 16'd1);
      wr(timer_pkg::CNT_OFS, 16'h0000); wr(timer_pkg::MODE_OFS, 16'h00ba); cyc(30);
      measure(1, hi, ed);
      `CHK(hi, 30)
      `CHK(ed, 20)
      measure(3, hi, ed);
      `CHK(hi, 30)
      `CHK(oen[3], 1'b0)
   endtask
   task automatic t_cutoff();
      logic [15:0] v;
      int n;
      wr(timer_pkg::OEN_OFS, 16'h0000); cutoff_n <= 1'b0; cyc(6);
      rd(timer_pkg::OEN_OFS, v); `CHK(v, 16'h0000)
      @(posedge clk); cutoff_n <= 1'b1; cyc(4); wr(timer_pkg::OEN_OFS, 16'h0080); cyc(1);
      `CHK(oen[1], 1'b0)
      @(posedge clk); cutoff_n <= 1'b0; n = 0;
      while (oen[1] === 1'b0 && n < 10) begin cyc(1); n++; end
      `CHK(n <= timer_pkg::CUT_CYC, 1'b1)
      `CHK(oen, 4'hf)
      rd(timer_pkg::OEN_OFS, v); `CHK(v, 16'h008f)
      @(posedge clk); cutoff_n <= 1'b1;
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset(); t_count(); t_sources(); t_compare(); t_overflow(); t_pwm(); t_buffer();
      t_cutoff();
      wrap_up();
   end
   // hang guard at 20000 cycles, well beyond the roughly 1800 cycles the run needs
   initial begin
      #(40 * 20000);
      error_cnt++;
      wrap_up();
   end
endmodule
